// ===== logic/bdc_pkg.sv
package bdc_pkg;
	// APB register byte offsets
	localparam logic [7:0] BDC_CMD_OFF    = 8'h00;
	localparam logic [7:0] BDC_ADDR_OFF   = 8'h04;
	localparam logic [7:0] BDC_WDATA0_OFF = 8'h08;
	localparam logic [7:0] BDC_WDATA1_OFF = 8'h0c;
	localparam logic [7:0] BDC_RDATA0_OFF = 8'h10;
	localparam logic [7:0] BDC_RDATA1_OFF = 8'h14;
	localparam logic [7:0] BDC_STAT_OFF   = 8'h18;
	localparam logic [7:0] BDC_CFG_OFF    = 8'h1c;
	// Field positions
	localparam int BDC_CMD_GO_BIT    = 0;
	localparam int BDC_CMD_RD_BIT    = 1;
	localparam int BDC_STAT_BUSY_BIT = 0;
	localparam int BDC_STAT_RDV_BIT  = 1;
	localparam int BDC_STAT_LOCK_BIT = 2;
	localparam int BDC_CFG_NOP2_BIT  = 0;
	localparam int BDC_CFG_SCM_BIT   = 1;
	localparam int BDC_CFG_DLL_BIT   = 2;
	localparam int BDC_CFG_BANK_LSB  = 4;
	// Reset values
	localparam logic [31:0] BDC_CFG_RST = 32'h0000_0004;
	// Timing
	localparam int BDC_CLK_MHZ       = 40;
	localparam int BDC_KDIV          = 2;
	localparam int BDC_DLL_LOCK_CYC  = 1024;
	localparam int BDC_DLL_RST_NS    = 30;
	localparam int BDC_DLL_RST_CYC   = (BDC_DLL_RST_NS * BDC_CLK_MHZ + 999) / 1000;
	localparam int BDC_RD_NOP_MIN    = 1;
	localparam int BDC_DW            = 18;
	localparam int BDC_AW            = 21;
	localparam int BDC_LANES         = 2;

	typedef struct packed {
		logic [BDC_AW-1:0] addr;
		logic              load_n;
		logic              rw;
		logic [BDC_LANES-1:0] byte_lane_sel_n;
	} bdc_ctl_t;

	typedef struct packed {
		logic [BDC_DW-1:0] dout;
		logic [BDC_DW-1:0] dout_en;
	} bdc_dq_t;

	typedef enum logic [2:0] {
		BDC_IDLE  = 3'b000,
		BDC_CMD   = 3'b001,
		BDC_BEAT1 = 3'b010,
		BDC_BEAT2 = 3'b011,
		BDC_NOP   = 3'b100,
		BDC_DLLW  = 3'b101
	} bdc_state_t;
endpackage

// ===== logic/bdc_sync.sv
`timescale 1ns/10ps
module bdc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] q_reg;
	logic [W-1:0] s1_next;
	logic [W-1:0] q_next;

	always_comb
	begin
		s1_next = d;
		q_next  = s1_reg;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_reg <= '0;
			q_reg  <= '0;
		end
		else
		begin
			s1_reg <= s1_next;
			q_reg  <= q_next;
		end
	end

	assign q = q_reg;
endmodule

// ===== logic/bdc_kgen.sv
`timescale 1ns/10ps
module bdc_kgen #(
	parameter int DIV = 2
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control
	input  wire logic run,
	// Clock out and phase pulses
	output logic      k_pos,
	output logic      k_rise,
	output logic      kn_rise
);
	import bdc_pkg::*;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic       k_reg;
	logic       k_next;
	logic       kr_reg;
	logic       kr_next;
	logic       knr_reg;
	logic       knr_next;

	// Counter is eight bits wide
	if (DIV < 1 || DIV > 255)
		$error("bdc_kgen: DIV out of range");

	// Half period of K is DIV pclk cycles; edge pulses rise with the pin, users act one pclk later
	always_comb
	begin
		cnt_next = cnt_reg;
		k_next   = k_reg;
		kr_next  = 1'b0;
		knr_next = 1'b0;
		if (!run)
		begin
			cnt_next = '0;
			k_next   = 1'b0;
		end
		else if (cnt_reg == 8'(DIV - 1))
		begin
			cnt_next = '0;
			k_next   = !k_reg;
			kr_next  = !k_reg;
			knr_next = k_reg;
		end
		else
			cnt_next = cnt_reg + 8'h01;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_reg <= '0;
			k_reg   <= 1'b0;
			kr_reg  <= 1'b0;
			knr_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			k_reg   <= k_next;
			kr_reg  <= kr_next;
			knr_reg <= knr_next;
		end
	end

	assign k_pos   = k_reg;
	assign k_rise  = kr_reg;
	assign kn_rise = knr_reg;
endmodule

// ===== logic/bdc_ctrl.sv
// Operation
// - Accesses start only on K rise
// - Read: rw high, load low
// - Reads back to back, never cut; here each read is one burst per go, with IDLE between
// - Write: rw low, load low
// - Two write words on K, then Kn
// - Writes back to back, pipelined; here each write is one burst per go, not pipelined
// - Hold output clocks high for single-clock
// - NOP between read and write
// - Separate load per bank
// - Stop clocks 30 ns resets DLL
`timescale 1ns/10ps
module bdc_ctrl #(
	parameter int NBANK = 2
) (
	// Clock and reset
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	// APB slave
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [7:0]                   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	// Memory clocks
	output logic                              k_clk,
	output logic                              kn_clk,
	output logic                              c_clk,
	output logic                              cn_clk,
	output logic                              dll_disable_n,
	// Memory control
	output bdc_pkg::bdc_ctl_t                 mem_ctl,
	output logic      [NBANK-1:0]             bank_load_n,
	// Memory data
	output bdc_pkg::bdc_dq_t                  mem_dq,
	input  wire logic [bdc_pkg::BDC_DW-1:0]   dq_in,
	input  wire logic                         echo_strobe_pos
);
	import bdc_pkg::*;

	// Bank select field is two bits wide
	if (NBANK < 1 || NBANK > 4)
		$error("bdc_ctrl: NBANK must be 1 to 4");

	logic k_pos;
	logic k_run_reg;
	logic k_run_next;
	logic k_rise;
	logic kn_rise;
	logic [BDC_DW-1:0] dq_s;
	logic              eq_s;

	bdc_kgen #(.DIV(BDC_KDIV)) u_kgen (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (k_run_reg),
		.k_pos   (k_pos),
		.k_rise  (k_rise),
		.kn_rise (kn_rise)
	);

	// Read data from the pins is asynchronous to pclk
	bdc_sync #(.W(BDC_DW + 1)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({echo_strobe_pos, dq_in}),
		.q       ({eq_s, dq_s})
	);

	// Software visible state
	logic [31:0]       cfg_reg,   cfg_next;
	logic [BDC_AW-1:0] addr_reg,  addr_next;
	logic [31:0]       wd0_reg,   wd0_next;
	logic [31:0]       wd1_reg,   wd1_next;
	logic [BDC_DW-1:0] rd0_reg,   rd0_next;
	logic [BDC_DW-1:0] rd1_reg,   rd1_next;
	logic              go_reg,    go_next;
	logic              isrd_reg,  isrd_next;
	logic              rdv_reg,   rdv_next;
	logic [31:0]       prdata_reg, prdata_next;
	logic              pready_reg, pready_next;
	logic              pslverr_reg, pslverr_next;
	// Memory side state
	bdc_state_t        st_reg,    st_next;
	bdc_ctl_t          ctl_reg,   ctl_next;
	bdc_dq_t           dq_reg,    dq_next;
	logic [NBANK-1:0]  bld_reg,   bld_next;
	logic              lastrd_reg, lastrd_next;
	logic [1:0]        nop_reg,   nop_next;
	logic [10:0]       lock_reg,  lock_next;
	logic              dll_q_reg, dll_q_next;
	logic [3:0]        stop_reg,  stop_next;
	logic [3:0]        beat_reg,  beat_next;

	wire apb_acc = psel && penable && !pready_reg;
	wire [1:0] bank_sel = cfg_reg[BDC_CFG_BANK_LSB +: 2];
	wire locked = (lock_reg == 11'(BDC_DLL_LOCK_CYC));
	wire burst_done = (st_reg == BDC_BEAT2) && kn_rise && (!isrd_reg || beat_reg == 4'h1);

	function automatic logic [BDC_AW-1:0] bdc_burst_addr(input logic [BDC_AW-1:0] a);
		// Second word flips address LSB
		// burst wraps
		bdc_burst_addr = {a[BDC_AW-1:1], !a[0]};
	endfunction

	always_comb
	begin
		cfg_next     = cfg_reg;
		addr_next    = addr_reg;
		wd0_next     = wd0_reg;
		wd1_next     = wd1_reg;
		go_next      = go_reg;
		isrd_next    = isrd_reg;
		prdata_next  = prdata_reg;
		pready_next  = 1'b0;
		pslverr_next = 1'b0;
		if (apb_acc)
		begin
			pready_next = 1'b1;
			if (pwrite)
				unique case (paddr)
					BDC_CMD_OFF:
					begin
						if (!go_reg)
						begin
							go_next   = pwdata[BDC_CMD_GO_BIT];
							isrd_next = pwdata[BDC_CMD_RD_BIT];
						end
					end
					BDC_ADDR_OFF:   addr_next = pwdata[BDC_AW-1:0];
					BDC_WDATA0_OFF: wd0_next  = pwdata;
					BDC_WDATA1_OFF: wd1_next  = pwdata;
					BDC_CFG_OFF:    cfg_next  = pwdata;
					default:        pslverr_next = !(paddr == BDC_RDATA0_OFF || paddr == BDC_RDATA1_OFF
					                                 || paddr == BDC_STAT_OFF);
				endcase
			else
				unique case (paddr)
					BDC_CMD_OFF:    prdata_next = {30'h0, isrd_reg, go_reg};
					BDC_ADDR_OFF:   prdata_next = {{(32-BDC_AW){1'b0}}, addr_reg};
					BDC_WDATA0_OFF: prdata_next = wd0_reg;
					BDC_WDATA1_OFF: prdata_next = wd1_reg;
					BDC_RDATA0_OFF: prdata_next = {14'h0, rd0_reg};
					BDC_RDATA1_OFF: prdata_next = {14'h0, rd1_reg};
					BDC_STAT_OFF:   prdata_next = {29'h0, locked, rdv_reg, go_reg};
					BDC_CFG_OFF:    prdata_next = cfg_reg;
					default:
					begin
						prdata_next  = 32'h0;
						pslverr_next = 1'b1;
					end
				endcase
		end
		if (burst_done)
			go_next = 1'b0;
	end

	always_comb
	begin
		st_next     = st_reg;
		ctl_next    = ctl_reg;
		dq_next     = dq_reg;
		bld_next    = bld_reg;
		lastrd_next = lastrd_reg;
		nop_next    = nop_reg;
		lock_next   = lock_reg;
		rd0_next    = rd0_reg;
		rd1_next    = rd1_reg;
		rdv_next    = rdv_reg;
		beat_next   = beat_reg;
		k_run_next  = 1'b1;
		dll_q_next  = dll_q_reg;
		stop_next   = stop_reg;
		if (k_rise && !locked)
			lock_next = lock_reg + 11'h001;
		unique case (st_reg)
			BDC_DLLW:
			begin
				if (locked || !cfg_reg[BDC_CFG_DLL_BIT])
					st_next = BDC_IDLE;
			end
			BDC_IDLE:
			begin
				if (go_reg && k_rise && !(lastrd_reg && !isrd_reg && nop_reg != 2'b00))
				begin
					ctl_next.load_n = 1'b0;
					ctl_next.rw     = isrd_reg;
					ctl_next.addr   = addr_reg;
					bld_next = ~(NBANK'(1) << bank_sel);
					ctl_next.byte_lane_sel_n = '1;
					if (!isrd_reg)
						rdv_next = rdv_reg;
					else
						rdv_next = 1'b0;
					st_next = BDC_CMD;
				end
				else if (k_rise)
				begin
					ctl_next.load_n = 1'b1;
					bld_next        = '1;
					if (nop_reg != 2'b00)
						nop_next = nop_reg - 2'h1;
				end
			end
			BDC_CMD:
			begin
				if (k_rise)
				begin
					ctl_next.load_n = 1'b1;
					bld_next        = '1;
					st_next         = BDC_BEAT1;
					beat_next       = 4'h0;
					if (!isrd_reg)
					begin
						dq_next.dout    = wd0_reg[BDC_DW-1:0];
						dq_next.dout_en = '1;
						ctl_next.byte_lane_sel_n = ~wd0_reg[BDC_DW +: BDC_LANES];
					end
				end
			end
			BDC_BEAT1:
			begin
				// Word 0 must still stand at the K rise after the command
				if (k_rise)
				begin
					st_next = BDC_BEAT2;
					if (!isrd_reg)
					begin
						// second word for the Kn rise
						dq_next.dout = wd1_reg[BDC_DW-1:0];
						ctl_next.byte_lane_sel_n = ~wd1_reg[BDC_DW +: BDC_LANES];
					end
				end
			end
			BDC_BEAT2:
			begin
				// two pclk of sync delay put each word half a K later
				if (isrd_reg && k_rise)
				begin
					rd0_next  = dq_s;
					beat_next = 4'h1;
				end
				if (burst_done)
				begin
					dq_next.dout_en = '0;
					ctl_next.byte_lane_sel_n = '1;
					if (isrd_reg)
					begin
						rd1_next = dq_s;
						rdv_next = 1'b1;
					end
					lastrd_next = isrd_reg;
					nop_next    = cfg_reg[BDC_CFG_NOP2_BIT] ? 2'h2 : 2'(BDC_RD_NOP_MIN);
					st_next     = BDC_IDLE;
				end
			end
			default: st_next = BDC_IDLE;
		endcase
		// re-enabling the DLL stops K so that it relocks
		if (stop_reg != 4'h0)
		begin
			k_run_next = 1'b0;
			lock_next  = '0;
			stop_next  = stop_reg - 4'h1;
		end
		else if (st_reg == BDC_IDLE && !go_reg && cfg_reg[BDC_CFG_DLL_BIT] != dll_q_reg)
		begin
			dll_q_next = cfg_reg[BDC_CFG_DLL_BIT];
			if (cfg_reg[BDC_CFG_DLL_BIT])
			begin
				k_run_next = 1'b0;
				lock_next  = '0;
				stop_next  = 4'(BDC_DLL_RST_CYC);
				st_next    = BDC_DLLW;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_reg     <= BDC_CFG_RST;
			addr_reg    <= '0;
			wd0_reg     <= '0;
			wd1_reg     <= '0;
			rd0_reg     <= '0;
			rd1_reg     <= '0;
			go_reg      <= 1'b0;
			isrd_reg    <= 1'b0;
			rdv_reg     <= 1'b0;
			prdata_reg  <= '0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			st_reg      <= BDC_DLLW;
			ctl_reg     <= '{addr: '0, load_n: 1'b1, rw: 1'b1, byte_lane_sel_n: '1};
			dq_reg      <= '0;
			bld_reg     <= '1;
			lastrd_reg  <= 1'b0;
			nop_reg     <= 2'h0;
			lock_reg    <= '0;
			k_run_reg   <= 1'b0;
			beat_reg    <= '0;
			dll_q_reg   <= BDC_CFG_RST[BDC_CFG_DLL_BIT];
			stop_reg    <= '0;
		end
		else
		begin
			cfg_reg     <= cfg_next;
			addr_reg    <= addr_next;
			wd0_reg     <= wd0_next;
			wd1_reg     <= wd1_next;
			rd0_reg     <= rd0_next;
			rd1_reg     <= rd1_next;
			go_reg      <= go_next;
			isrd_reg    <= isrd_next;
			rdv_reg     <= rdv_next;
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			st_reg      <= st_next;
			ctl_reg     <= ctl_next;
			dq_reg      <= dq_next;
			bld_reg     <= bld_next;
			lastrd_reg  <= lastrd_next;
			nop_reg     <= nop_next;
			lock_reg    <= lock_next;
			k_run_reg   <= k_run_next;
			beat_reg    <= beat_next;
			dll_q_reg   <= dll_q_next;
			stop_reg    <= stop_next;
		end
	end

	// Single clock mode: C pair held high, a strap, so change cfg only before lock
	// strap option
	assign c_clk         = cfg_reg[BDC_CFG_SCM_BIT] | k_pos;
	assign cn_clk        = cfg_reg[BDC_CFG_SCM_BIT] | !k_pos;
	assign k_clk         = k_pos;
	assign kn_clk        = !k_pos;
	assign dll_disable_n = cfg_reg[BDC_CFG_DLL_BIT];
	assign mem_ctl       = ctl_reg;
	assign bank_load_n   = bld_reg;
	assign mem_dq        = dq_reg;
	assign prdata        = prdata_reg;
	assign pready        = pready_reg;
	assign pslverr       = pslverr_reg;

	a_nop_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		(st_reg == BDC_IDLE && lastrd_reg && nop_reg != 2'b00 && !isrd_reg) |=> ctl_reg.load_n)
		else $error("write issued without NOP after read");
	a_cmd_on_krise: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(ctl_reg.load_n) |-> $past(k_rise))
		else $error("command launched off K rise");
	a_load_one_k: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(ctl_reg.load_n) |=> !ctl_reg.load_n [*3])
		else $error("load pulse shorter than one K period");
	a_wr_drive: assert property (@(posedge pclk) disable iff (!presetn)
		(st_reg == BDC_CMD && k_rise && !isrd_reg) |=> (mem_dq.dout_en == '1))
		else $error("write data not driven");
	a_rd_nodrive: assert property (@(posedge pclk) disable iff (!presetn)
		(isrd_reg && st_reg != BDC_IDLE) |-> (mem_dq.dout_en == '0))
		else $error("bus driven during read");
	a_burst_done: assert property (@(posedge pclk) disable iff (!presetn)
		(st_reg == BDC_CMD && k_rise) |=> ##[1:12] (st_reg == BDC_IDLE))
		else $error("burst did not complete");
	a_one_bank: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot0(~bld_reg))
		else $error("more than one bank loaded");
	a_lanes_idle: assert property (@(posedge pclk) disable iff (!presetn)
		(st_reg == BDC_IDLE) |-> (ctl_reg.byte_lane_sel_n == '1))
		else $error("lane select active while idle");
	c_read:  cover property (@(posedge pclk) st_reg == BDC_BEAT2 && isrd_reg && kn_rise);
	c_write: cover property (@(posedge pclk) st_reg == BDC_BEAT2 && !isrd_reg && kn_rise);
	c_nop:   cover property (@(posedge pclk) st_reg == BDC_IDLE && go_reg && lastrd_reg && nop_reg != 2'b00);
	c_echo:  cover property (@(posedge pclk) $rose(eq_s));
endmodule

// ===== testbench/bdc_mem_model.sv
`timescale 1ns/10ps
module bdc_mem_model (
	// Clocks from the controller
	input  wire logic                  k_clk,
	input  wire logic                  kn_clk,
	input  wire logic                  c_clk,
	input  wire logic                  cn_clk,
	// Command, bank load and write data
	input  wire bdc_pkg::bdc_ctl_t     mem_ctl,
	input  wire logic                  load_n,
	input  wire bdc_pkg::bdc_dq_t      mem_dq,
	// Read data and echo
	output logic [bdc_pkg::BDC_DW-1:0] dq_in,
	output logic                       echo_strobe_pos
);
	import bdc_pkg::*;
	logic [BDC_DW-1:0] mem [int];
	logic [BDC_DW-1:0] q = '0;
	logic              drv = 1'b0;
	int                seq = 0;
	// both output clocks high selects the input pair
	wire               scm = c_clk & cn_clk;
	wire               oc = scm ? k_clk : c_clk;
	wire               ocn = scm ? kn_clk : cn_clk;
	assign echo_strobe_pos = oc;
	// output impedance retuned every 1024 K cycles; only the cadence is kept
	int                zq_cnt = 0;
	always @(posedge k_clk)
		zq_cnt <= (zq_cnt == 1023) ? 0 : zq_cnt + 1;
	// Released bus shows a changed level, not the last word
	assign dq_in = drv ? q : ~q;

	function automatic logic [BDC_DW-1:0] rdw(input int a);
		return mem.exists(a) ? mem[a] : '0;
	endfunction

	// a lane that is not selected keeps its contents
	function automatic void put(input int a, input logic [BDC_DW-1:0] d, input logic [1:0] ln);
		logic [BDC_DW-1:0] o;
		o = rdw(a);
		if (!ln[0])
			o[8:0] = d[8:0];
		if (!ln[1])
			o[17:9] = d[17:9];
		mem[a] = o;
	endfunction

	// word at Kn t+1, flipped word at C t+2, released one C later
	task automatic rd_burst(input int a);
		int s;
		@(posedge k_clk);
		@(posedge ocn);
		seq++;
		s = seq;
		q = rdw(a);
		drv = 1'b1;
		@(posedge oc);
		q = rdw(a ^ 1);
		@(posedge oc);
		if (s == seq)
			drv = 1'b0;
	endtask

	// first word on K, second on Kn, lanes sampled with each
	task automatic wr_burst(input int a);
		@(posedge k_clk);
		put(a, mem_dq.dout, mem_ctl.byte_lane_sel_n);
		@(posedge kn_clk);
		put(a ^ 1, mem_dq.dout, mem_ctl.byte_lane_sel_n);
	endtask

	// commands taken on K rise only, by this bank's load
	always @(posedge k_clk)
	begin
		if (load_n === 1'b0)
		begin
			if (mem_ctl.rw)
				fork rd_burst(int'(mem_ctl.addr)); join_none
			else
				fork wr_burst(int'(mem_ctl.addr)); join_none
		end
	end
endmodule

// ===== testbench/tb_bdc_ctrl.sv
`timescale 1ns/10ps
module tb_bdc_ctrl;
	import bdc_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, slv;
	logic        k_clk, kn_clk, c_clk, cn_clk, dll_disable_n, echo_strobe_pos;
	bdc_ctl_t    mem_ctl;
	bdc_dq_t     mem_dq;
	logic [1:0]  bank_load_n;
	logic [17:0] dq_in;
	logic [31:0] seed = 32'd5057;
	logic [17:0] shadow [int];
	int          err_total = 0;
	int          n_tests = 0;
	int          kcnt = 0;
	int          rd_k = -9;
	int          bank = 0;
	int          nop = 1;

	always #12.5 pclk = ~pclk;

	bdc_ctrl #(.NBANK(2)) u_bdc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .k_clk, .kn_clk, .c_clk, .cn_clk, .dll_disable_n, .mem_ctl, .bank_load_n,
		.mem_dq, .dq_in, .echo_strobe_pos);
	bdc_mem_model u_bdc_mem_model (.k_clk, .kn_clk, .c_clk, .cn_clk, .mem_ctl, .load_n(bank_load_n[0]),
		.mem_dq, .dq_in, .echo_strobe_pos);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [17:0] sh(input int a);
		return shadow.exists(a) ? shadow[a] : '0;
	endfunction

	function automatic logic [17:0] mrg(input logic [17:0] o, input logic [17:0] d, input logic [1:0] l);
		return {l[1] ? d[17:9] : o[17:9], l[0] ? d[8:0] : o[8:0]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		// One idle edge between transfers, so psel is never assigned twice in a step
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic go(input logic rd_op);
		logic [31:0] r;
		int n;
		apb(1'b1, BDC_CMD_OFF, {30'h0, rd_op, 1'b1}, r);
		n = 0;
		do
		begin
			apb(1'b0, BDC_STAT_OFF, 32'h0, r);
			n++;
		end
		while (r[BDC_STAT_BUSY_BIT] !== 1'b0 && n < 200);
		chk("busy", 0, r[BDC_STAT_BUSY_BIT]);
	endtask

	task automatic mwr(input int a, input logic [17:0] d0, input logic [17:0] d1, input logic [1:0] l0,
		input logic [1:0] l1);
		logic [31:0] r;
		apb(1'b1, BDC_ADDR_OFF, a, r);
		apb(1'b1, BDC_WDATA0_OFF, {12'h0, l0, d0}, r);
		apb(1'b1, BDC_WDATA1_OFF, {12'h0, l1, d1}, r);
		go(1'b0);
		shadow[a] = mrg(sh(a), d0, l0);
		shadow[a ^ 1] = mrg(sh(a ^ 1), d1, l1);
	endtask

	task automatic mrd(input int a);
		logic [31:0] r;
		apb(1'b1, BDC_ADDR_OFF, a, r);
		go(1'b1);
		apb(1'b0, BDC_RDATA0_OFF, 32'h0, r);
		chk("rd0", {14'h0, sh(a)}, {14'h0, r[17:0]});
		apb(1'b0, BDC_RDATA1_OFF, 32'h0, r);
		chk("rd1", {14'h0, sh(a ^ 1)}, {14'h0, r[17:0]});
	endtask

	// Each load always after lock, on the selected bank only; a write more than nop K rises after a read
	always @(posedge k_clk)
	begin
		kcnt++;
		if (mem_ctl.load_n === 1'b0)
		begin
			chk("lock", 1, kcnt > 1024);
			chk("bank", 2'(~(2'b01 << bank)), bank_load_n);
			if (mem_ctl.rw === 1'b0)
				chk("nop", 1, kcnt - rd_k > nop);
			else
				rd_k = kcnt;
		end
	end

	initial
	begin
		#(40000 * 25);
		err_total++;
		close_out();
	end

	initial
	begin
		logic [31:0] r, d0, d1;
		int a, i, n;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("load", 1, mem_ctl.load_n);
		chk("banks", 3, bank_load_n);
		chk("den", 0, mem_dq.dout_en);
		chk("dll_disable_n", 1, dll_disable_n);
		apb(1'b0, BDC_CFG_OFF, 32'h0, r);
		chk("cfg", BDC_CFG_RST, r);
		apb(1'b0, 8'h40, 32'h0, r);
		chk("slverr", 1, slv);
		n = 0;
		do
		begin
			apb(1'b0, BDC_STAT_OFF, 32'h0, r);
			n++;
		end
		while (r[BDC_STAT_LOCK_BIT] !== 1'b1 && n < 3000);
		chk("locked", 1, r[BDC_STAT_LOCK_BIT]);
		$display("reset and lock test done");
		for (i = 0; i < 16; i++)
		begin
			a = (i == 15) ? 21'h1fffff : rnd() % 8;
			d0 = rnd();
			d1 = rnd();
			mwr(a, d0[17:0], d1[17:0], i[1:0], i[3:2]);
			mrd(a);
			mrd(a ^ 1);
		end
		$display("write and read test done");
		nop = 2;
		apb(1'b1, BDC_CFG_OFF, 32'h5, r);
		mrd(3);
		mwr(3, 18'h2aaaa, 18'h15555, 2'b11, 2'b11);
		nop = 1;
		apb(1'b1, BDC_CFG_OFF, 32'h6, r);
		@(posedge pclk);
		repeat (8)
		begin
			@(posedge pclk);
			chk("cpair", 3, {c_clk, cn_clk});
		end
		mrd(3);
		$display("nop and single clock test done");
		bank = 1;
		apb(1'b1, BDC_CFG_OFF, 32'h14, r);
		apb(1'b1, BDC_ADDR_OFF, 32'h2, r);
		go(1'b1);
		bank = 0;
		apb(1'b1, BDC_CFG_OFF, 32'h0, r);
		repeat (2) @(posedge pclk);
		chk("dll_disable_n", 0, dll_disable_n);
		apb(1'b1, BDC_CFG_OFF, 32'h4, r);
		apb(1'b0, BDC_STAT_OFF, 32'h0, r);
		chk("relock", 0, r[BDC_STAT_LOCK_BIT]);
		$display("bank and dll test done");
		close_out();
	end
endmodule
